// ---- eplc_pkg.sv ----
// Package: register map, field positions, reset values and timing constants
package eplc_pkg;

   // ===========================================================
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_PULSE_VAL = 8'h04;
   localparam logic [7:0] ADDR_PULSE_LEN = 8'h08;
   localparam logic [7:0] ADDR_PULSE_ST  = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK  = 8'h14;
   localparam logic [7:0] ADDR_GRP_CFG   = 8'h18;
   localparam logic [7:0] ADDR_LEAD      = 8'h1c;
   localparam logic [7:0] ADDR_MINON     = 8'h20;
   localparam logic [7:0] ADDR_CMP_SEL   = 8'h24;
   localparam logic [7:0] ADDR_CMP_LIMIT = 8'h28;
   localparam logic [7:0] ADDR_CMP_MODE  = 8'h2c;
   localparam logic [7:0] ADDR_CMP_RUN   = 8'h30;
   localparam logic [7:0] ADDR_GRP_OUT   = 8'h34;

   // ===========================================================
   // Control register fields
   localparam int CTRL_PULSE_EN = 0;
   localparam int CTRL_NEG_SIGN = 1;
   localparam int CTRL_SRC_REAC = 2;
   localparam int CTRL_BACKSTOP = 3;
   localparam int CTRL_W        = 4;

   // Comparator mode fields
   localparam int MODE_EN    = 0;
   localparam int MODE_UNDER = 1;
   localparam int MODE_SRC   = 2;
   localparam int MODE_W     = 3;

   // Interrupt status fields
   localparam int IRQ_PULSE = 0;
   localparam int IRQ_GRP   = 1;
   localparam int IRQ_OVF   = 6;
   localparam int IRQ_W     = 7;

   // ===========================================================
   // Sizes
   localparam int NUM_GRP = 5;
   localparam int CMP_PER_GRP = 10;
   localparam int NUM_CMP = NUM_GRP * CMP_PER_GRP;
   localparam int SEL_W = 6;
   localparam int PEND_W = 16;
   localparam int ACC_W = 56;

   // ===========================================================
   // Reset values
   localparam logic [CTRL_W-1:0] CTRL_RST  = 4'h0;
   localparam logic [15:0] PULSE_LEN_RST   = 16'h001e;
   localparam logic [31:0] PULSE_VAL_RST   = 32'h0000000a;
   localparam logic [15:0] LEAD_RST        = 16'h0000;
   localparam logic [15:0] MINON_RST       = 16'h0000;

   // ===========================================================
   // Timing
   localparam int CLK_HZ = 50_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int MS_PER_H = 3_600_000;
   localparam int BLINK_MS = 500;
   localparam logic [15:0] BLINK_TICKS = 16'(BLINK_MS / TICK_MS);

   // Pulse generator states
   typedef enum logic [2:0] {
      PS_IDLE = 3'b001,
      PS_HIGH = 3'b010,
      PS_GAP  = 3'b100
   } eplc_pstate_t;

endpackage

// ---- eplc_cmp.sv ----
// One limit comparator with lead time, minimum switch-on time and running time
module eplc_cmp (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        tick,
   input  wire logic        viol,
   input  wire logic [15:0] lead_ms,
   input  wire logic [15:0] minon_ms,
   output logic             result,
   output logic [31:0]      runtime
);
   import eplc_pkg::*;

   logic [15:0] lead_cnt;
   logic [15:0] on_cnt;

   // =====================================================
   // Lead timer: counts whole ms of unbroken violation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lead_cnt <= 16'h0000;
      end else if (!viol) begin
         lead_cnt <= 16'h0000;
      end else if (tick && lead_cnt != 16'hffff) begin
         lead_cnt <= lead_cnt + 16'h0001;
      end
   end

   // =====================================================
   // Result: set after lead time, held for min on time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result <= 1'b0;
         on_cnt <= 16'h0000;
      end else if (!result) begin
         on_cnt <= 16'h0000;
         if (viol && lead_cnt >= lead_ms) begin
            result <= 1'b1;
         end
      end else begin
         if (tick && on_cnt != 16'hffff) begin
            on_cnt <= on_cnt + 16'h0001;
         end
         if (!viol && on_cnt >= minon_ms) begin
            result <= 1'b0;
         end
      end
   end

   // =====================================================
   // Running time in ms; the min on extension is not counted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         runtime <= 32'h00000000;
      end else if (tick && result && viol && runtime != 32'hffffffff) begin
         runtime <= runtime + 32'h00000001;
      end
   end

   AST_HOLD_MINON: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(result) |-> $past(on_cnt) >= $past(minon_ms) && !$past(viol))
      else $error("result cleared before min on time or during violation");
   AST_LEAD_BEFORE_SET: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(result) |-> $past(lead_cnt) >= $past(lead_ms) && $past(viol))
      else $error("result set before lead time elapsed");
   AST_RUN_ONLY_VIOL: assert property (@(posedge pclk) disable iff (!presetn)
      !viol |=> runtime == $past(runtime))
      else $error("running time grew without violation");
endmodule

// ---- eplc_top.sv ----
// Energy pulse output and limit comparator block with APB register access
//
// Decided for this implementation: the register addresses and register access over APB.
module eplc_top #(
   parameter int TICK_DIV = eplc_pkg::TICK_CYC
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic signed [31:0]    meas_active,
   input  wire logic signed [31:0]    meas_reactive,
   output logic                       pulse_out,
   output logic [eplc_pkg::NUM_GRP-1:0] grp_out,
   output logic                       backlight_max,
   output logic                       irq
);
   import eplc_pkg::*;

   // Absolute value with the most negative input saturated
   function automatic logic [31:0] mag(input logic signed [31:0] v);
      if (v == 32'sh80000000) begin
         return 32'h7fffffff;
      end
      return v[31] ? 32'(-v) : 32'(v);
   endfunction

   logic [CTRL_W-1:0]   ctrl;
   logic [31:0]         pulse_val;
   logic [15:0]         pulse_len;
   logic [IRQ_W-1:0]    irq_stat;
   logic [IRQ_W-1:0]    irq_mask;
   logic [NUM_GRP-1:0]  grp_and;
   logic [NUM_GRP-1:0]  grp_blink;
   logic [15:0]         lead_ms;
   logic [15:0]         minon_ms;
   logic [SEL_W-1:0]    cmp_sel;
   logic signed [31:0]  cmp_limit [NUM_CMP];
   logic [MODE_W-1:0]   cmp_mode  [NUM_CMP];
   logic [31:0]         cmp_run   [NUM_CMP];
   logic [NUM_CMP-1:0]  cmp_res;
   logic [NUM_CMP-1:0]  cmp_viol;
   logic [31:0]         tick_cnt;
   logic                tick;
   logic [ACC_W-1:0]    acc;
   logic [ACC_W-1:0]    thresh;
   logic [PEND_W-1:0]   pending;
   logic [15:0]         seg_cnt;
   logic [15:0]         eff_len;
   logic [15:0]         blink_cnt;
   logic [NUM_GRP-1:0]  grp_calc;
   eplc_pstate_t        pstate;
   logic signed [31:0]  pwr;
   logic                acc_allow;
   logic                acc_ge;
   logic                pulse_start;
   logic                pend_ovf;
   logic                wr_en;
   logic                rd_done;
   logic                sel_ok;
   logic                rd_stat;

   // =====================================================
   // Millisecond tick; every time base uses this one enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= 32'h00000000;
         tick <= 1'b0;
      end else if (tick_cnt >= 32'(TICK_DIV - 1)) begin
         tick_cnt <= 32'h00000000;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h00000001;
         tick <= 1'b0;
      end
   end

   // =====================================================
   // APB decode; writes at the access edge, zero wait states
   assign wr_en = psel && penable && pready && pwrite;
   assign rd_done = psel && penable && pready && !pwrite;
   assign rd_stat = rd_done && paddr == ADDR_IRQ_STAT;
   assign sel_ok = cmp_sel < SEL_W'(NUM_CMP);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && (paddr > ADDR_GRP_OUT || paddr[1:0] != 2'b00);
      end
   end

   // Read data is latched in the setup cycle so it comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            ADDR_CTRL:      prdata <= 32'(ctrl);
            ADDR_PULSE_VAL: prdata <= pulse_val;
            ADDR_PULSE_LEN: prdata <= 32'(pulse_len);
            ADDR_PULSE_ST:  prdata <= {15'h0000, pulse_out, pending};
            ADDR_IRQ_STAT:  prdata <= 32'(irq_stat);
            ADDR_IRQ_MASK:  prdata <= 32'(irq_mask);
            ADDR_GRP_CFG:   prdata <= {22'h000000, grp_blink, grp_and};
            ADDR_LEAD:      prdata <= 32'(lead_ms);
            ADDR_MINON:     prdata <= 32'(minon_ms);
            ADDR_CMP_SEL:   prdata <= 32'(cmp_sel);
            ADDR_CMP_LIMIT: prdata <= sel_ok ? cmp_limit[cmp_sel] : 32'h00000000;
            ADDR_CMP_MODE:  prdata <= sel_ok ? 32'(cmp_mode[cmp_sel]) : 32'h00000000;
            ADDR_CMP_RUN:   prdata <= sel_ok ? cmp_run[cmp_sel] : 32'h00000000;
            ADDR_GRP_OUT:   prdata <= 32'(grp_out);
            default:        prdata <= 32'h00000000;
         endcase
      end
   end

   // =====================================================
   // Writable configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RST;
         pulse_val <= PULSE_VAL_RST;
         pulse_len <= PULSE_LEN_RST;
         irq_mask <= '0;
         grp_and <= '0;
         grp_blink <= '0;
         lead_ms <= LEAD_RST;
         minon_ms <= MINON_RST;
         cmp_sel <= '0;
      end else if (wr_en) begin
         unique case (paddr)
            ADDR_CTRL:      ctrl <= pwdata[CTRL_W-1:0];
            ADDR_PULSE_VAL: pulse_val <= pwdata;
            ADDR_PULSE_LEN: pulse_len <= pwdata[15:0];
            ADDR_IRQ_MASK:  irq_mask <= pwdata[IRQ_W-1:0];
            ADDR_GRP_CFG:   {grp_blink, grp_and} <= pwdata[2*NUM_GRP-1:0];
            ADDR_LEAD:      lead_ms <= pwdata[15:0];
            ADDR_MINON:     minon_ms <= pwdata[15:0];
            ADDR_CMP_SEL:   cmp_sel <= pwdata[SEL_W-1:0];
            default:        ;
         endcase
      end
   end

   // Per comparator limit and mode, reached through the select index
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_CMP; i++) begin
            cmp_limit[i] <= '0;
            cmp_mode[i] <= '0;
         end
      end else if (wr_en && sel_ok) begin
         if (paddr == ADDR_CMP_LIMIT) begin
            cmp_limit[cmp_sel] <= pwdata;
         end
         if (paddr == ADDR_CMP_MODE) begin
            cmp_mode[cmp_sel] <= pwdata[MODE_W-1:0];
         end
      end
   end

   // =====================================================
   // Energy accumulation with sign filter and backstop
   assign pwr = ctrl[CTRL_SRC_REAC] ? meas_reactive : meas_active;
   always_comb begin
      if (ctrl[CTRL_BACKSTOP]) begin
         acc_allow = pwr > 0;
      end else if (ctrl[CTRL_NEG_SIGN]) begin
         acc_allow = pwr < 0;
      end else begin
         acc_allow = pwr > 0;
      end
   end
   // Pulse value in Wh (or varh) scaled to power times milliseconds
   assign thresh = ACC_W'(pulse_val) * ACC_W'(MS_PER_H);
   assign acc_ge = ctrl[CTRL_PULSE_EN] && thresh != '0 && acc >= thresh;

   // Power added every ms, so pulse spacing follows the power
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc <= '0;
      end else if (!ctrl[CTRL_PULSE_EN]) begin
         acc <= '0;
      end else begin
         acc <= acc + ((tick && acc_allow) ? ACC_W'(mag(pwr)) : '0)
                    - (acc_ge ? thresh : '0);
      end
   end

   // =====================================================
   // Pending count absorbs bursts faster than the pulse frame
   assign pulse_start = pstate == PS_IDLE && pending != '0;
   assign pend_ovf = acc_ge && !pulse_start && pending == '1;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending <= '0;
      end else if (acc_ge && !pulse_start && pending != '1) begin
         pending <= pending + PEND_W'(1);
      end else if (!acc_ge && pulse_start) begin
         pending <= pending - PEND_W'(1);
      end
   end

   // =====================================================
   // Pulse frame: high for the length, then low for the same length
   assign eff_len = (pulse_len == 16'h0000) ? 16'h0001 : pulse_len;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pstate <= PS_IDLE;
         pulse_out <= 1'b0;
         seg_cnt <= 16'h0000;
      end else begin
         unique case (pstate)
            PS_IDLE: begin
               seg_cnt <= 16'h0000;
               if (pulse_start) begin
                  pstate <= PS_HIGH;
                  pulse_out <= 1'b1;
               end
            end
            PS_HIGH: begin
               if (tick) begin
                  if (seg_cnt + 16'h0001 >= eff_len) begin
                     pstate <= PS_GAP;
                     pulse_out <= 1'b0;
                     seg_cnt <= 16'h0000;
                  end else begin
                     seg_cnt <= seg_cnt + 16'h0001;
                  end
               end
            end
            PS_GAP: begin
               if (tick) begin
                  if (seg_cnt + 16'h0001 >= eff_len) begin
                     pstate <= PS_IDLE;
                     seg_cnt <= 16'h0000;
                  end else begin
                     seg_cnt <= seg_cnt + 16'h0001;
                  end
               end
            end
            default: begin
               pstate <= PS_IDLE;
               pulse_out <= 1'b0;
            end
         endcase
      end
   end

   // =====================================================
   // Comparators: five groups of ten
   for (genvar c = 0; c < NUM_CMP; c++) begin : g_cmp
      assign cmp_viol[c] = cmp_mode[c][MODE_EN] &&
         (cmp_mode[c][MODE_UNDER]
            ? ((cmp_mode[c][MODE_SRC] ? meas_reactive : meas_active) < cmp_limit[c])
            : ((cmp_mode[c][MODE_SRC] ? meas_reactive : meas_active) > cmp_limit[c]));
      eplc_cmp u_cmp (
         .pclk     (pclk),
         .presetn  (presetn),
         .tick     (tick),
         .viol     (cmp_viol[c]),
         .lead_ms  (lead_ms),
         .minon_ms (minon_ms),
         .result   (cmp_res[c]),
         .runtime  (cmp_run[c])
      );
   end

   // Group logic; AND only looks at enabled comparators
   always_comb begin
      for (int g = 0; g < NUM_GRP; g++) begin
         logic [CMP_PER_GRP-1:0] en;
         logic [CMP_PER_GRP-1:0] r;
         en = '0;
         r = cmp_res[g*CMP_PER_GRP +: CMP_PER_GRP];
         for (int k = 0; k < CMP_PER_GRP; k++) begin
            en[k] = cmp_mode[g*CMP_PER_GRP+k][MODE_EN];
         end
         grp_calc[g] = grp_and[g] ? (en != '0 && (r | ~en) == '1) : (r != '0);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         grp_out <= '0;
      end else begin
         grp_out <= grp_calc;
      end
   end

   // =====================================================
   // Backlight blink; full brightness when no blinking group is active
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         backlight_max <= 1'b1;
         blink_cnt <= 16'h0000;
      end else if ((grp_blink & grp_out) == '0) begin
         backlight_max <= 1'b1;
         blink_cnt <= 16'h0000;
      end else if (tick) begin
         if (blink_cnt + 16'h0001 >= BLINK_TICKS) begin
            blink_cnt <= 16'h0000;
            backlight_max <= !backlight_max;
         end else begin
            blink_cnt <= blink_cnt + 16'h0001;
         end
      end
   end

   // =====================================================
   // Sticky events, read-to-clear; a new event wins over the clear
   // Only bits that the read returned are cleared: an event in the setup cycle survives
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= '0;
         irq <= 1'b0;
      end else begin
         irq_stat <= (irq_stat & ~(rd_stat ? prdata[IRQ_W-1:0] : '0))
                   | {pend_ovf, grp_calc & ~grp_out, pulse_start};
         irq <= (irq_stat & irq_mask) != '0;
      end
   end

   // =====================================================
   // Checks
   AST_PULSE_HIGH_LEN: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(pulse_out) |-> $past(seg_cnt) + 16'h0001 >= $past(eff_len))
      else $error("pulse high phase shorter than pulse length");
   AST_GAP_LEN: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(pulse_out) |-> $past(pstate) == PS_IDLE)
      else $error("pulse restarted without full gap");
   AST_GAP_DONE: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(pstate) == PS_GAP && pstate == PS_IDLE) |->
         $past(seg_cnt) + 16'h0001 >= $past(eff_len))
      else $error("gap ended early");
   AST_SIGN_FILTER: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && !acc_allow && ctrl[CTRL_PULSE_EN]) |=> acc <= $past(acc))
      else $error("energy accumulated against sign filter");
   AST_BACKSTOP: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl[CTRL_BACKSTOP] && pwr <= 0) |-> !acc_allow)
      else $error("backstop let exported energy count");
   AST_NO_LOSS: assert property (@(posedge pclk) disable iff (!presetn)
      (acc_ge && !pulse_start && pending != '1) |=> pending == $past(pending) + PEND_W'(1))
      else $error("pulse credit lost");
   AST_GROUP: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> grp_out == $past(grp_calc))
      else $error("group output not following combined result");
   AST_BLINK_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      (grp_blink & grp_out) == '0 |=> backlight_max)
      else $error("backlight dimmed without blinking group");
   AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      ((irq_stat & irq_mask) != '0) |=> irq)
      else $error("interrupt not raised");
   AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready)
      else $error("apb access not ready after setup");

   COV_PULSE: cover property (@(posedge pclk) disable iff (!presetn) $rose(pulse_out));
   COV_QUEUE: cover property (@(posedge pclk) disable iff (!presetn) pending > PEND_W'(1));
   COV_GROUP: cover property (@(posedge pclk) disable iff (!presetn) $rose(grp_out[0]));
   COV_BLINK: cover property (@(posedge pclk) disable iff (!presetn) $fell(backlight_max));
endmodule

// ---- eplc_rcv.sv ----
// Pulse receiver model: counts pulses and keeps the shortest low gap
module eplc_rcv (
   input  wire logic pclk,
   input  wire logic pulse_in,
   output int        count,
   output int        min_gap
);
   int   cnt  = 0;
   int   gap  = 1000000;
   int   low  = 0;
   logic last = 1'b0;
   assign count   = cnt;
   assign min_gap = gap;
   // ==========================================
   // Sampling
   // Passive: pulse value and length are the host's choice to suit this receiver
   always @(posedge pclk) begin
      if (pulse_in === 1'b1 && last !== 1'b1) begin
         cnt <= cnt + 1;
         if (cnt > 0 && low < gap)
            gap <= low;
      end
      low  <= (pulse_in === 1'b1) ? 0 : low + 1;
      last <= pulse_in;
   end
endmodule

// ---- eplc_top_tb.sv ----
// Self-checking bench for the energy pulse and limit comparator block
module eplc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import eplc_pkg::*;
   localparam int TD = 10;
   typedef struct {logic [3:0] ctrl; int act; int reac; int np;} eplc_row_t;
   logic               pclk    = 1'b0;
   logic               presetn = 1'b0;
   logic               psel    = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite  = 1'b0;
   logic [7:0]         paddr   = 8'h00;
   logic [31:0]        pwdata  = 32'h0;
   logic signed [31:0] meas_active   = 32'sh0;
   logic signed [31:0] meas_reactive = 32'sh0;
   logic [31:0]        prdata, rd;
   logic               pready, pslverr, pulse_out, backlight_max, irq, err;
   logic [NUM_GRP-1:0] grp_out;
   int                 n_fail = 0, check_count = 0, count, min_gap, base, i;
   // Sign filter cases: control, active, reactive, pulses expected
   eplc_row_t rows[8] = '{'{4'h1, 1800000, 0, 5}, '{4'h1, -1800000, 0, 0},
      '{4'h3, -1800000, 0, 5}, '{4'h3, 1800000, 0, 0}, '{4'hb, -1800000, 0, 0},
      '{4'h5, 0, 1800000, 5}, '{4'h1, 3600000, 0, 10}, '{4'hf, 0, -1800000, 0}};
   // ==========================================
   // Clock and instances
   always #10 pclk = ~pclk;
   eplc_top #(.TICK_DIV(TD)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .meas_active(meas_active),
      .meas_reactive(meas_reactive), .pulse_out(pulse_out), .grp_out(grp_out),
      .backlight_max(backlight_max), .irq(irq));
   eplc_rcv rcv (.pclk(pclk), .pulse_in(pulse_out), .count(count), .min_gap(min_gap));
   // ==========================================
   // Tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (n_fail == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (k == 20) begin
         n_fail++;
         close_out();
      end
   endtask
   // ==========================================
   // Main sequence
   initial begin
      cyc(8);
      presetn <= 1'b1;
      apb(1, ADDR_PULSE_VAL, 32'h1);
      apb(1, ADDR_PULSE_LEN, 32'h2);
      foreach (rows[r]) begin
         apb(1, ADDR_CTRL, 32'h0);
         apb(1, ADDR_CTRL, {28'h0, rows[r].ctrl});
         base = count;
         @(posedge pclk);
         meas_active   <= rows[r].act;
         meas_reactive <= rows[r].reac;
         cyc(100);
         meas_active   <= 32'sh0;
         meas_reactive <= 32'sh0;
         for (i = 0; i < 300; i++) begin
            apb(0, ADDR_PULSE_ST, 32'h0);
            if (rd[16:0] === 17'h0)
               break;
         end
         if (i == 300) begin
            n_fail++;
            close_out();
         end
         cyc(30);
         chk(count - base, rows[r].np);
      end
      chk(min_gap >= 2 * TD, 1);
      chk(irq, 1'b0);
      apb(1, ADDR_IRQ_MASK, 32'h1);
      cyc(2);
      chk(irq, 1'b1);
      apb(0, ADDR_IRQ_STAT, 32'h0);
      chk(rd[0], 1'b1);
      cyc(2);
      chk(irq, 1'b0);
      apb(1, 8'h38, 32'hffff);
      chk(err, 1'b1);
      apb(0, 8'h38, 32'h0);
      chk(rd, 32'h0);
      // Second reset in mid-run
      presetn <= 1'b0;
      cyc(8);
      chk({pulse_out, irq, backlight_max, grp_out}, {3'b001, 5'h0});
      chk(prdata, 32'h0);
      chk({pready, pslverr}, 2'b00);
      presetn <= 1'b1;
      apb(0, ADDR_PULSE_LEN, 32'h0);
      chk(rd, 32'h1e);
      apb(0, ADDR_PULSE_VAL, 32'h0);
      chk(rd, 32'ha);
      // Comparator 0: over 100, lead 3 ms, minimum on 5 ms
      apb(1, ADDR_LEAD, 32'h3);
      apb(1, ADDR_MINON, 32'h5);
      apb(1, ADDR_CMP_SEL, 32'h0);
      apb(1, ADDR_CMP_LIMIT, 32'd100);
      apb(1, ADDR_CMP_MODE, 32'h1);
      @(posedge pclk);
      meas_active <= 32'sd200;
      cyc(15);
      chk(grp_out[0], 1'b0);
      cyc(35);
      chk(grp_out, 5'h01);
      meas_active <= 32'sh0;
      cyc(15);
      chk(grp_out[0], 1'b1);
      cyc(60);
      chk(grp_out[0], 1'b0);
      apb(0, ADDR_CMP_RUN, 32'h0);
      chk(rd inside {[1:3]}, 1'b1);
      // Group 0 in AND mode with a second comparator that never trips
      apb(1, ADDR_GRP_CFG, 32'h1);
      apb(1, ADDR_CMP_SEL, 32'h1);
      apb(1, ADDR_CMP_LIMIT, 32'd1000);
      apb(1, ADDR_CMP_MODE, 32'h1);
      @(posedge pclk);
      meas_active <= 32'sd200;
      cyc(50);
      chk(grp_out[0], 1'b0);
      // Same group in OR mode with blinking; half period is 500 ticks
      apb(1, ADDR_GRP_CFG, 32'h20);
      cyc(2);
      chk(grp_out[0], 1'b1);
      chk(backlight_max, 1'b1);
      cyc(5050);
      chk(backlight_max, 1'b0);
      meas_active <= 32'sh0;
      cyc(100);
      chk({grp_out[0], backlight_max}, 2'b01);
      close_out();
   end
endmodule
